// ### hdl/mcpc_pkg.sv
// Constants, register map and helpers for the master clock PLL control.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package mcpc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned MON_WINDOW_US = 10;
  localparam int unsigned MON_WINDOW_CYC = MON_WINDOW_US * CLK_MHZ;
  localparam logic [15:0] MON_MIN_TICKS = 16'h0010;
  localparam logic [15:0] MON_MAX_TICKS = 16'h0400;

  // ==========================================================
  // Frequency limits in Hz
  localparam logic [39:0] PD_MIN_HZ = 40'd9_720_000;
  localparam logic [39:0] PD_MAX_HZ = 40'd102_400_000;
  localparam logic [31:0] REF_MAX_HZ = 32'd750_000_000;
  localparam logic [31:0] BLOCK_MIN_HZ = 32'd1;
  localparam logic [31:0] PLL_MIN_HZ = 32'd9_720_000;
  localparam logic [31:0] DIFF_MAX_HZ = 32'd750_000_000;
  localparam logic [31:0] SE_MAX_HZ = 32'd160_000_000;

  // ==========================================================
  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_MCFG1 = 8'h00;
  localparam logic [7:0] A_MCFG2 = 8'h04;
  localparam logic [7:0] A_PCFG1 = 8'h08;
  localparam logic [7:0] A_PCFG2 = 8'h0c;
  localparam logic [7:0] A_FBMUL = 8'h10;
  localparam logic [7:0] A_NDEN = 8'h14;
  localparam logic [7:0] A_NINT = 8'h18;
  localparam logic [7:0] A_ADJ = 8'h1c;
  localparam logic [7:0] A_REFHZ = 8'h20;
  localparam logic [7:0] A_IN1HZ = 8'h24;
  localparam logic [7:0] A_IN2HZ = 8'h28;
  localparam logic [7:0] A_INFMT = 8'h2c;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_LSTAT = 8'h34;
  localparam logic [7:0] A_CLR = 8'h38;
  localparam logic [7:0] A_IEN = 8'h3c;

  // ==========================================================
  // Field positions
  localparam int B_ICB_EN = 0;
  localparam int B_DPLL_MODE = 1;
  localparam int B_OSC_EN = 0;
  localparam int B_IN1_EN = 1;
  localparam int B_IN2_EN = 2;
  localparam int F_DIV_LO = 8;
  localparam int F_DIV_HI = 15;
  localparam int B_PLL_EN = 8;
  localparam int B_SRC_SEL = 0;
  localparam int B_IN1_DIFF = 0;
  localparam int B_IN1_PLL = 1;
  localparam int B_IN2_DIFF = 2;
  localparam int B_IN2_PLL = 3;
  localparam int B_REF_LOSS = 0;

  // ==========================================================
  // Reset values; nominal settings describe a 204.8 MHz master clock
  localparam logic [31:0] MCLK_DEFAULT_KHZ = 32'd204_800;
  localparam logic [31:0] NDEN_RST = 32'h0000_0001;
  localparam logic [31:0] NINT_RST = MCLK_DEFAULT_KHZ;
  localparam logic [31:0] ADJ_RST = 32'h0000_0000;

  function automatic logic in_range(input logic [39:0] f,
                                    input logic [39:0] lo,
                                    input logic [39:0] hi);
    in_range = (f >= lo) && (f <= hi);
  endfunction : in_range

endpackage : mcpc_pkg

// ### hdl/mcpc_mon_if.sv
// Carrier between the control top and its reference activity monitor.
// Assumes all signals are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface mcpc_mon_if;
  logic tick;
  logic enable;
  logic fail;
  modport ctl (output tick, output enable, input fail);
  modport mon (input tick, input enable, output fail);
endinterface : mcpc_mon_if
`default_nettype wire

// ### hdl/mcpc_ref_mon.sv
// Reference activity monitor: counts reference ticks over a fixed window.
// Assumes ticks are single-cycle pulses synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module mcpc_ref_mon
  import mcpc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Synchronous reset
  mcpc_mon_if.mon mon // Tick in, fail out
);

  logic [15:0] win_cnt;
  logic [15:0] tick_cnt;
  logic win_end;

  assign win_end = (win_cnt == 16'(MON_WINDOW_CYC - 1));

  // ==========================================================
  // Window timer
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !mon.enable || win_end) begin
      win_cnt <= 16'h0000;
    end else begin
      win_cnt <= win_cnt + 16'h0001;
    end
  end

  // Saturates so a wild reference cannot wrap into range
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !mon.enable || win_end) begin
      tick_cnt <= 16'h0000;
    end else if (mon.tick && tick_cnt != 16'hffff) begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Verdict at window end
  // [RL10] stopped or gross
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !mon.enable) begin
      mon.fail <= 1'b0;
    end else if (win_end) begin
      mon.fail <= (tick_cnt < MON_MIN_TICKS) || (tick_cnt > MON_MAX_TICKS);
    end
  end

endmodule : mcpc_ref_mon
`default_nettype wire

// ### hdl/mcpc_in_chk.sv
// Acceptance check of one input clock against its format and route limits.
// Assumes software writes the expected input frequency in Hz.
`timescale 1ns/10ps
`default_nettype none
module mcpc_in_chk
  import mcpc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Synchronous reset
  input wire logic enable, // Receiver enabled
  input wire logic diff, // Differential format
  input wire logic to_pll, // Routed straight to the PLLs
  input wire logic [31:0] freq_hz, // Expected frequency
  output logic ok // Frequency acceptable
);

  logic [31:0] lo;
  logic [31:0] hi;

  // [RL15] block route limits
  // [RL16] PLL route limits
  assign lo = to_pll ? PLL_MIN_HZ : BLOCK_MIN_HZ;
  assign hi = diff ? DIFF_MAX_HZ : SE_MAX_HZ;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ok <= 1'b0;
    end else begin
      ok <= enable && in_range({8'h00, freq_hz}, {8'h00, lo}, {8'h00, hi});
    end
  end

endmodule : mcpc_in_chk
`default_nettype wire

// ### hdl/mcpc_top.sv
// Master clock PLL control: registers, reference monitor and enables.
// Assumes an APB master on sys_clk, an analog PLL on the outputs and
// prescaled reference ticks.
//
// How it works
// [RL1] Master clock routed only in DPLL mode
// [RL2] PLL output feeds input block and DPLL
// [RL3] Source select picks oscillator pins or crystal
// [RL4] Phase detector frequency kept 9.72-102.4MHz
// [RL5] Input divider brings up to 750MHz down
// [RL6] Software picks dividers for 190-208.333MHz
// [RL7] Reset assumes 204.8MHz master clock
// [RL8] Software reprograms nominal settings otherwise
// [RL9] PLL keeps running when reference stops
// [RL10] Stopped or gross reference sets loss flag
// [RL11] Loss flag interrupts only when enabled
// [RL12] Oscillator input off until enable set
// [RL13] Zero divide field disables master divider
// [RL14] Each input receiver has own enable
// [RL15] Input block accepts 1Hz-750/160MHz
// [RL16] Direct PLL route accepts from 9.72MHz
// [RL17] Input block runs only when enabled
// [RL18] Loss flag sticky until software clears
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module mcpc_top
  import mcpc_pkg::*;
(
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic ext_osc_tick, // Oscillator pin prescaled tick
  input wire logic xtal_tick, // Crystal prescaled tick
  output logic osc_input_enable, // Oscillator pin receiver on
  output logic input_one_enable, // Input one receiver on
  output logic input_two_enable, // Input two receiver on
  output logic input_block_enable, // Input block on
  output logic pll_enable, // Master clock PLL on
  output logic pll_source_select, // 0 pins, 1 crystal
  output logic [7:0] pll_input_divider, // Input divider minus one
  output logic [31:0] pll_feedback_multiplier, // Feedback multiplier
  output logic [7:0] pll_high_speed_divider, // High-speed divider
  output logic [7:0] master_clock_divide_field, // Master divider
  output logic master_clock_divider_enable, // Master divider on
  output logic master_clock_route_enable, // Clock to block and DPLL
  output logic [31:0] nominal_denominator_setting, // Nominal denominator
  output logic [31:0] nominal_integer_setting, // Nominal integer
  output logic [31:0] master_clock_adjust_setting, // Adjust value
  output logic pd_freq_ok, // Phase detector input in range
  output logic input_one_ok, // Input one frequency acceptable
  output logic input_two_ok, // Input two frequency acceptable
  output logic reference_loss, // Live reference failure
  output logic irq // Level interrupt
);

  // ==========================================================
  // Register storage
  logic [31:0] mcfg1;
  logic [31:0] mcfg2;
  logic [31:0] pcfg1;
  logic [31:0] pcfg2;
  logic [31:0] ref_hz;
  logic [31:0] in1_hz;
  logic [31:0] in2_hz;
  logic [31:0] infmt;
  logic [31:0] int_en;
  logic reference_loss_flag;

  // ==========================================================
  // APB decode
  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic [31:0] next_prdata;
  logic [31:0] live_stat;
  logic clr_loss;
  logic loss_event;
  logic in1_ok_w;
  logic in2_ok_w;
  logic [39:0] div_ratio;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready;

  always_comb begin
    unique case (paddr)
      A_MCFG1, A_MCFG2, A_PCFG1, A_PCFG2, A_FBMUL, A_NDEN, A_NINT,
      A_ADJ, A_REFHZ, A_IN1HZ, A_IN2HZ, A_INFMT, A_STAT, A_LSTAT,
      A_CLR, A_IEN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign live_stat = {27'h0, input_two_ok, input_one_ok, pd_freq_ok,
                      master_clock_divider_enable, reference_loss};

  always_comb begin
    unique case (paddr)
      A_MCFG1: next_prdata = mcfg1;
      A_MCFG2: next_prdata = mcfg2;
      A_PCFG1: next_prdata = pcfg1;
      A_PCFG2: next_prdata = pcfg2;
      A_FBMUL: next_prdata = pll_feedback_multiplier;
      A_NDEN: next_prdata = nominal_denominator_setting;
      A_NINT: next_prdata = nominal_integer_setting;
      A_ADJ: next_prdata = master_clock_adjust_setting;
      A_REFHZ: next_prdata = ref_hz;
      A_IN1HZ: next_prdata = in1_hz;
      A_IN2HZ: next_prdata = in2_hz;
      A_INFMT: next_prdata = infmt;
      A_STAT: next_prdata = live_stat;
      A_LSTAT: next_prdata = {31'h0, reference_loss_flag};
      A_IEN: next_prdata = int_en;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // No wait state: captured in setup, ready in access
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_ph && !mapped;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mcfg1 <= 32'h0000_0000;
      mcfg2 <= 32'h0000_0000;
      pcfg1 <= 32'h0000_0000;
      pcfg2 <= 32'h0000_0000;
      pll_feedback_multiplier <= 32'h0000_0000;
      ref_hz <= 32'h0000_0000;
      in1_hz <= 32'h0000_0000;
      in2_hz <= 32'h0000_0000;
      infmt <= 32'h0000_0000;
      int_en <= 32'h0000_0000;
    end else if (wr_acc) begin
      unique case (paddr)
        A_MCFG1: mcfg1 <= pwdata;
        A_MCFG2: mcfg2 <= pwdata;
        A_PCFG1: pcfg1 <= pwdata;
        A_PCFG2: pcfg2 <= pwdata;
        A_FBMUL: pll_feedback_multiplier <= pwdata;
        A_REFHZ: ref_hz <= pwdata;
        A_IN1HZ: in1_hz <= pwdata;
        A_IN2HZ: in2_hz <= pwdata;
        A_INFMT: infmt <= pwdata;
        A_IEN: int_en <= pwdata;
        default: ;
      endcase
    end
  end

  // [RL7] default 204.8MHz
  // [RL8] nominal settings writable
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      nominal_denominator_setting <= NDEN_RST;
      nominal_integer_setting <= NINT_RST;
      master_clock_adjust_setting <= ADJ_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        A_NDEN: nominal_denominator_setting <= pwdata;
        A_NINT: nominal_integer_setting <= pwdata;
        A_ADJ: master_clock_adjust_setting <= pwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Enables and analog configuration outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      osc_input_enable <= 1'b0;
      input_one_enable <= 1'b0;
      input_two_enable <= 1'b0;
      input_block_enable <= 1'b0;
    end else begin
      // [RL12] oscillator input gate
      osc_input_enable <= mcfg2[B_OSC_EN];
      // [RL14] per-input receiver enables
      input_one_enable <= mcfg2[B_IN1_EN];
      input_two_enable <= mcfg2[B_IN2_EN];
      // [RL17] input block gate
      input_block_enable <= mcfg1[B_ICB_EN];
    end
  end

  // Loss never gates the PLL, which self-oscillates through it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pll_enable <= 1'b0;
      pll_source_select <= 1'b0;
      pll_input_divider <= 8'h00;
      pll_high_speed_divider <= 8'h00;
    end else begin
      // [RL9] no shutdown on loss
      pll_enable <= pcfg1[B_PLL_EN];
      // [RL3] reference source select
      pll_source_select <= pcfg2[B_SRC_SEL];
      // [RL5] programmable input divider
      pll_input_divider <= pcfg2[F_DIV_HI:F_DIV_LO];
      pll_high_speed_divider <= pcfg1[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      master_clock_divide_field <= 8'h00;
      master_clock_divider_enable <= 1'b0;
      master_clock_route_enable <= 1'b0;
    end else begin
      master_clock_divide_field <= mcfg2[F_DIV_HI:F_DIV_LO];
      // [RL13] zero field disables
      master_clock_divider_enable <= |mcfg2[F_DIV_HI:F_DIV_LO];
      // [RL1] DPLL mode only
      // [RL2] feed input block and DPLL
      master_clock_route_enable <= mcfg1[B_DPLL_MODE] &&
                                   pcfg1[B_PLL_EN] &&
                                   (|mcfg2[F_DIV_HI:F_DIV_LO]);
    end
  end

  // ==========================================================
  // Phase detector range check
  assign div_ratio = {32'h0, pll_input_divider} + 40'd1;

  // Products fit 40 bits: 102.4e6 * 256 is below 2^35
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pd_freq_ok <= 1'b0;
    end else begin
      // [RL4] phase detector window
      // [RL5] reference up to 750MHz
      pd_freq_ok <= ({8'h00, ref_hz} <= {8'h00, REF_MAX_HZ}) &&
                    in_range({8'h00, ref_hz},
                             40'(PD_MIN_HZ * div_ratio),
                             40'(PD_MAX_HZ * div_ratio));
    end
  end

  // ==========================================================
  // Input clock acceptance
  mcpc_in_chk u_in1_chk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .enable(mcfg2[B_IN1_EN]),
    .diff(infmt[B_IN1_DIFF]),
    .to_pll(infmt[B_IN1_PLL]),
    .freq_hz(in1_hz),
    .ok(in1_ok_w)
  );

  mcpc_in_chk u_in2_chk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .enable(mcfg2[B_IN2_EN]),
    .diff(infmt[B_IN2_DIFF]),
    .to_pll(infmt[B_IN2_PLL]),
    .freq_hz(in2_hz),
    .ok(in2_ok_w)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      input_one_ok <= 1'b0;
      input_two_ok <= 1'b0;
    end else begin
      input_one_ok <= in1_ok_w;
      input_two_ok <= in2_ok_w;
    end
  end

  // ==========================================================
  // Reference monitor
  mcpc_mon_if mon_if ();

  // [RL3] monitor the selected source
  // [RL12] disabled pins give no ticks
  assign mon_if.tick = pcfg2[B_SRC_SEL] ? xtal_tick
                                        : (ext_osc_tick && mcfg2[B_OSC_EN]);
  assign mon_if.enable = pcfg1[B_PLL_EN];

  mcpc_ref_mon u_ref_mon (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mon(mon_if.mon)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reference_loss <= 1'b0;
    end else begin
      reference_loss <= mon_if.fail;
    end
  end

  // ==========================================================
  // Latched status and interrupt
  assign loss_event = mon_if.fail && !reference_loss;
  assign clr_loss = wr_acc && (paddr == A_CLR) && pwdata[B_REF_LOSS];

  // [RL10] latch on failure
  // [RL18] sticky, set beats clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reference_loss_flag <= 1'b0;
    end else if (loss_event) begin
      reference_loss_flag <= 1'b1;
    end else if (clr_loss) begin
      reference_loss_flag <= 1'b0;
    end
  end

  // [RL11] enabled flag only
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= reference_loss_flag && int_en[B_REF_LOSS];
    end
  end

endmodule : mcpc_top
`default_nettype wire

// ### verif/mcpc_osc_model.sv
// Reference oscillator model: one-cycle prescaled ticks at a set period.
// Assumes the bench sets and stops it.
`timescale 1ns/10ps
`default_nettype none
module mcpc_osc_model (
  input wire logic sys_clk, // System clock
  input wire logic run, // Oscillating
  input wire logic [7:0] period, // Cycles per tick
  output logic tick // Prescaled edge pulse
);
  logic [7:0] cnt = 8'h00;
  // ====================
  // Tick generation
  // bench keeps rate legal
  always @(posedge sys_clk) begin
    if (!run || cnt >= period - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  // Stopped oscillator gives a flat line, not a stuck pulse
  assign tick = run && (cnt == period - 8'h01);
endmodule : mcpc_osc_model
`default_nettype wire

// ### verif/mcpc_top_props.sv
// Checker on the control top's ports.
// Assumes a bind into mcpc_top.
`timescale 1ns/10ps
`default_nettype none
module mcpc_top_props
  import mcpc_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic osc_input_enable, // Pin receiver on
  input wire logic input_one_enable, // Input one on
  input wire logic input_two_enable, // Input two on
  input wire logic input_block_enable, // Input block on
  input wire logic pll_enable, // PLL on
  input wire logic pll_source_select, // Source select
  input wire logic [7:0] master_clock_divide_field, // Divider
  input wire logic master_clock_divider_enable, // Divider on
  input wire logic master_clock_route_enable, // Route on
  input wire logic [31:0] nominal_denominator_setting, // Nominal den
  input wire logic [31:0] nominal_integer_setting, // Nominal int
  input wire logic irq // Interrupt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic acc_w;
  assign acc_w = psel && penable && pready && pwrite;
  // ====================
  // Assertions
  chk_ready_wait: assert property ( // APB no wait state
    psel && !penable |=> pready ##1 !pready)
    else $error("bad ready wait");
  chk_cfg2_copy: assert property (
    acc_w && paddr == A_MCFG2 |=> ##1
    {input_two_enable, input_one_enable, osc_input_enable}
    == $past(pwdata[2:0], 2))
    else $error("bad rx enables");
  chk_cfg1_copy: assert property (
    acc_w && paddr == A_MCFG1 |=> ##1
    input_block_enable == $past(pwdata[B_ICB_EN], 2))
    else $error("bad block enable");
  chk_src_copy: assert property (
    acc_w && paddr == A_PCFG2 |=> ##1
    pll_source_select == $past(pwdata[B_SRC_SEL], 2))
    else $error("bad source");
  chk_div_gate: assert property (
    master_clock_divider_enable == (master_clock_divide_field != 8'h00))
    else $error("bad divider enable");
  chk_route_gate: assert property (
    master_clock_route_enable |-> pll_enable && master_clock_divider_enable)
    else $error("bad route");
  chk_reset_nom: assert property (
    $rose(rst_b) |-> nominal_integer_setting == NINT_RST
    && nominal_denominator_setting == NDEN_RST)
    else $error("bad nominal reset");
  chk_irq_sticky: assert property (
    $fell(irq) |->
    $past(acc_w && (paddr == A_CLR || paddr == A_IEN), 2))
    else $error("bad irq fall");
endmodule : mcpc_top_props
bind mcpc_top mcpc_top_props u_props (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .osc_input_enable, .input_one_enable,
  .input_two_enable, .input_block_enable, .pll_enable, .pll_source_select,
  .master_clock_divide_field, .master_clock_divider_enable,
  .master_clock_route_enable, .nominal_denominator_setting,
  .nominal_integer_setting, .irq);
`default_nettype wire

// ### verif/mcpc_top_tb_top.sv
// Self-checking bench for the master clock PLL control top.
// Assumes oscillator models drive both tick inputs.
`timescale 1ns/10ps
`default_nettype none
module mcpc_top_tb_top
  import mcpc_pkg::*;
();
  logic sys_clk, rst_b, psel, penable, pwrite, err, osc_run, xtal_run;
  logic [7:0] paddr, osc_per, pll_input_divider, pll_high_speed_divider;
  logic [7:0] master_clock_divide_field;
  logic [31:0] pwdata, prdata, rd, pll_feedback_multiplier;
  logic [31:0] nominal_denominator_setting, nominal_integer_setting;
  logic [31:0] master_clock_adjust_setting;
  logic pready, pslverr, ext_osc_tick, xtal_tick, osc_input_enable;
  logic input_one_enable, input_two_enable, input_block_enable, pll_enable;
  logic pll_source_select, master_clock_divider_enable, input_one_ok;
  logic master_clock_route_enable, pd_freq_ok, input_two_ok;
  logic reference_loss, irq;
  int errors, checks;
  // Divider, Hz, in range
  localparam logic [40:0] PD_TAB [7] = '{
    {8'h00, 32'h9450c0, 1'b1}, {8'h00, 32'h9450bf, 1'b0},
    {8'h00, 32'h61a8000, 1'b1}, {8'h00, 32'h61a8001, 1'b0},
    {8'h07, 32'h4a285ff, 1'b0}, {8'h07, 32'h2cb41780, 1'b1},
    {8'h07, 32'h2cb41781, 1'b0}};
  // Format (0 diff, 1 PLL), Hz, ok; last entry passes
  localparam logic [34:0] IN_TAB [9] = '{
    {2'h1, 32'h1, 1'b1}, {2'h1, 32'h0, 1'b0},
    {2'h1, 32'h2cb41780, 1'b1}, {2'h1, 32'h2cb41781, 1'b0},
    {2'h0, 32'h9896800, 1'b1}, {2'h0, 32'h9896801, 1'b0},
    {2'h3, 32'h9450bf, 1'b0}, {2'h2, 32'h9896801, 1'b0},
    {2'h3, 32'h9450c0, 1'b1}};

  mcpc_top DUT (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_osc_tick, .xtal_tick, .osc_input_enable,
    .input_one_enable, .input_two_enable, .input_block_enable, .pll_enable,
    .pll_source_select, .pll_input_divider, .pll_feedback_multiplier,
    .pll_high_speed_divider, .master_clock_divide_field,
    .master_clock_divider_enable, .master_clock_route_enable,
    .nominal_denominator_setting, .nominal_integer_setting,
    .master_clock_adjust_setting, .pd_freq_ok, .input_one_ok,
    .input_two_ok, .reference_loss, .irq);
  // Disabled pins give no ticks
  mcpc_osc_model u_pins (.sys_clk, .run(osc_run && osc_input_enable),
    .period(osc_per), .tick(ext_osc_tick));
  mcpc_osc_model u_xtal (.sys_clk, .run(xtal_run), .period(8'h14),
    .tick(xtal_tick));

  // ====================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_loss(input logic want);
    int n;
    n = 0;
    while (reference_loss !== want && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (reference_loss !== want) begin
      errors++;
      results();
    end
  endtask : wait_loss

  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // ====================
  // Scenarios
  task automatic t_reset();
    chk("nom_int", nominal_integer_setting, NINT_RST);
    apb(1'b0, A_NDEN, 32'h0);
    chk("nden_rd", rd, 32'h1);
    apb(1'b1, A_NINT, 32'h30d40);
    apb(1'b1, A_ADJ, 32'h7);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    chk("nom_set", {nominal_integer_setting[23:0],
      master_clock_adjust_setting[7:0]}, 32'h030d4007);
  endtask : t_reset

  task automatic t_enables();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_MCFG2, 32'(1 << i));
      idle(3);
      chk("rx_en", 32'({input_two_enable, input_one_enable,
        osc_input_enable}), 32'(1 << i));
      chk("div_off", 32'(master_clock_divider_enable), 32'h0);
    end
    apb(1'b1, A_MCFG2, 32'h200);
    apb(1'b1, A_PCFG1, 32'h10a);
    apb(1'b1, A_FBMUL, 32'h50);
    apb(1'b1, A_MCFG1, 32'h3);
    idle(3);
    chk("div_on", 32'(master_clock_divider_enable), 32'h1);
    chk("dividers", 32'({pll_high_speed_divider,
      master_clock_divide_field}), 32'ha02);
    chk("fb_mul", pll_feedback_multiplier, 32'h50);
    chk("blk_en", 32'(input_block_enable), 32'h1);
    chk("route", 32'(master_clock_route_enable), 32'h1);
    apb(1'b1, A_MCFG1, 32'h1);
    idle(3);
    chk("route_apll", 32'(master_clock_route_enable), 32'h0);
  endtask : t_enables

  task automatic t_pd();
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, A_PCFG2, {16'h0000, PD_TAB[i][40:33], 7'h00, 1'(i)});
      apb(1'b1, A_REFHZ, PD_TAB[i][32:1]);
      idle(4);
      chk("src_sel", 32'(pll_source_select), 32'(i % 2));
      chk("in_div", 32'(pll_input_divider), 32'(PD_TAB[i][40:33]));
      chk("pd_ok", 32'(pd_freq_ok), 32'(PD_TAB[i][0]));
    end
  endtask : t_pd

  task automatic t_inputs();
    apb(1'b1, A_MCFG2, 32'h6);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, A_INFMT, 32'({2{IN_TAB[i][34:33]}}));
      apb(1'b1, A_IN1HZ, IN_TAB[i][32:1]);
      apb(1'b1, A_IN2HZ, IN_TAB[i][32:1]);
      idle(4);
      chk("in1_ok", 32'(input_one_ok), 32'(IN_TAB[i][0]));
      chk("in2_ok", 32'(input_two_ok), 32'(IN_TAB[i][0]));
    end
    apb(1'b1, A_MCFG2, 32'h2);
    idle(4);
    chk("in_en", 32'({input_two_ok, input_one_ok}), 32'h1);
  endtask : t_inputs

  task automatic t_loss();
    apb(1'b1, A_MCFG2, 32'h1);
    apb(1'b1, A_PCFG2, 32'h0);
    idle(1100);
    chk("loss_idle", 32'(reference_loss), 32'h0);
    apb(1'b1, A_CLR, 32'h1);
    osc_run <= 1'b0;
    wait_loss(1'b1);
    idle(3);
    chk("irq_masked", 32'(irq), 32'h0);
    chk("pll_on", 32'(pll_enable), 32'h1);
    apb(1'b0, A_LSTAT, 32'h0);
    chk("flag_set", rd, 32'h1);
    apb(1'b1, A_IEN, 32'h1);
    idle(2);
    chk("irq_on", 32'(irq), 32'h1);
    // Twelve ticks a window is gross
    osc_per <= 8'h28;
    osc_run <= 1'b1;
    idle(1100);
    chk("loss_slow", 32'(reference_loss), 32'h1);
    osc_per <= 8'h14;
    wait_loss(1'b0);
    chk("irq_sticky", 32'(irq), 32'h1);
    apb(1'b1, A_CLR, 32'h1);
    idle(2);
    chk("irq_clr", 32'(irq), 32'h0);
    apb(1'b1, A_PCFG2, 32'h1);
    osc_run <= 1'b0;
    idle(1100);
    chk("xtal_ok", 32'(reference_loss), 32'h0);
    apb(1'b1, A_PCFG2, 32'h0);
    wait_loss(1'b1);
  endtask : t_loss

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    errors = 0;
    checks = 0;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {osc_run, xtal_run, osc_per} = {2'h3, 8'h14};
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_enables();
    t_pd();
    t_inputs();
    t_loss();
    results();
  end
endmodule : mcpc_top_tb_top
`default_nettype wire
